/* File: hdl/fetch_seq_pkg.sv */
package fetch_seq_pkg;
   // Bus widths
   localparam int instr_addr_width = 20;
   localparam int emul_addr_width = 16;
   localparam int word_width = 16;
   // Native opcode field, top six bits of the instruction word
   localparam int opcode_msb = 15;
   localparam int opcode_lsb = 10;
   localparam logic [5:0] op_load_from_instr_mem = 6'h1C;
   localparam logic [5:0] op_store_to_instr_mem = 6'h1D;
   localparam logic [5:0] op_internal_input_cmd = 6'h1A;
   localparam logic [5:0] op_output_register_cmd = 6'h1B;
   localparam logic [5:0] op_load_operand = 6'h10;
   localparam logic [5:0] op_store_operand = 6'h11;
   localparam logic [5:0] op_macro_return = 6'h1F;
   localparam logic [5:0] op_word_done = 6'h1E;
   localparam logic [5:0] op_count = 6'h1E;
   // Native instruction count and usual cycle count
   localparam int native_instr_count = 30;
   localparam int native_cycles = 2;
   // Emulation opcode field positions and special opcodes
   localparam int emul_op_msb = 15;
   localparam int emul_op_lsb = 8;
   localparam logic [7:0] builtin_function_opcode = 8'h4F;
   localparam logic [7:0] multiword_move_opcode = 8'h93;
   // Macro table: base plus opcode times spacing; builtin variants at builtin_base, overlapping the entries of opcodes F0 to FF
   localparam logic [15:0] macro_base = 16'h0100;
   localparam int macro_shift = 4;
   localparam logic [15:0] builtin_base = 16'h1000;
   localparam int builtin_shift = 4;
   // Emulation discrete bit positions and reset values
   localparam int dma_enable_bit = 16;
   localparam int power_ok_bit = 17;
   localparam int startup_rom_bit = 18;
   localparam int chip_select_bit = 19;
   localparam logic [3:0] discrete_reset = 4'h1;
   localparam logic [15:0] first_emul_addr = 16'h0000;
   localparam logic [19:0] native_reset_addr = 20'h00000;
   // Output register command selector for discretes
   localparam logic [3:0] discrete_select = 4'h8;
endpackage

/* File: hdl/operand_bus_if.sv */
interface operand_bus_if;
   import fetch_seq_pkg::*;
   logic start;
   logic write;
   logic [15:0] addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic done;
   modport master (output start, output write, output addr, output wdata,
      input rdata, input done);
   modport slave (input start, input write, input addr, input wdata,
      output rdata, output done);
endinterface

/* File: hdl/operand_bus_arbiter.sv */
module operand_bus_arbiter
   import fetch_seq_pkg::*;
(
   input wire logic clk_sys, // System clock
   input wire logic reset, // Sync reset, high
   operand_bus_if.slave req, // Request from sequencer
   input wire logic bus_grant_in, // Grant from arbiter
   input wire logic bus_busy_in, // Previous master still on bus
   input wire logic transfer_ack_n, // Slave ready, low
   input wire logic [15:0] op_data_in, // Operand data bus in
   output logic bus_request_out, // Request bus
   output logic grant_acknowledge_out, // Bus owned
   output logic addr_strobe_n, // Address valid, low
   output logic data_strobe_n, // Data valid, low
   output logic [15:0] op_addr_out, // Operand address
   output logic [15:0] op_data_out, // Operand write data
   output logic op_data_oe_n // Data drive enable, low
);
   typedef enum logic [3:0] {
      st_idle = 4'h1,
      st_request = 4'h2,
      st_strobe = 4'h4,
      st_release = 4'h8
   } arb_state_type;
   arb_state_type state;
   logic grant_seen;
   logic busy_seen;
   logic [15:0] rdata;
   logic write_op;

   ////////////////////////////////////////////////////////////////
   // Falling-edge sample of grant and busy
   always_ff @(negedge clk_sys) begin
      if (reset) begin
         grant_seen <= 1'b0;
         busy_seen <= 1'b1;
      end else begin
         grant_seen <= bus_grant_in; // RQ9
         busy_seen <= bus_busy_in; // RQ9
      end
   end

   // Request raised on the falling edge, mid cycle after start
   always_ff @(negedge clk_sys) begin
      if (reset) begin
         bus_request_out <= 1'b0;
      end else if (state == st_request && !grant_acknowledge_out) begin
         bus_request_out <= 1'b1; // RQ8
      end else if (state == st_release || state == st_idle) begin
         bus_request_out <= 1'b0; // RQ24
      end
   end

   ////////////////////////////////////////////////////////////////
   // Ownership and strobe sequence
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state <= st_idle;
         grant_acknowledge_out <= 1'b0;
         addr_strobe_n <= 1'b1;
         data_strobe_n <= 1'b1;
         op_addr_out <= 16'h0000;
         op_data_out <= 16'h0000;
         op_data_oe_n <= 1'b1;
         rdata <= 16'h0000;
         write_op <= 1'b0;
      end else begin
         case (state)
            st_idle: begin
               if (req.start) begin
                  op_addr_out <= req.addr;
                  op_data_out <= req.wdata;
                  write_op <= req.write; // Only stands in the start cycle
                  state <= st_request;
               end
            end
            st_request: begin
               // Take bus only once previous master let go
               if (bus_request_out && grant_seen && !busy_seen) begin
                  grant_acknowledge_out <= 1'b1; // RQ10
                  addr_strobe_n <= 1'b0; // RQ11
                  data_strobe_n <= 1'b0; // RQ11
                  op_data_oe_n <= !write_op;
                  state <= st_strobe;
               end
            end
            st_strobe: begin
               // Slow slaves stretch the cycle by holding ack off
               if (!transfer_ack_n) begin // RQ12
                  rdata <= op_data_in;
                  addr_strobe_n <= 1'b1;
                  data_strobe_n <= 1'b1;
                  op_data_oe_n <= 1'b1;
                  state <= st_release;
               end
            end
            st_release: begin
               grant_acknowledge_out <= 1'b0; // RQ24
               state <= st_idle;
            end
            default: state <= st_idle;
         endcase
      end
   end

   assign req.done = (state == st_release);
   assign req.rdata = rdata;
endmodule

/* File: hdl/macro_address_map.sv */
module macro_address_map
   import fetch_seq_pkg::*;
(
   input wire logic [15:0] emul_instr, // Fetched emulated instruction
   output logic [15:0] macro_addr, // Macro entry in instruction memory
   output logic is_multiword_move // Word-granular interrupts
);
   // Builtin variants take the low byte as index, 256 entries
   always_comb begin
      if (emul_instr[emul_op_msb:emul_op_lsb] == builtin_function_opcode) begin
         macro_addr = builtin_base + 16'({8'h00, emul_instr[7:0]} << builtin_shift); // RQ22
      end else begin
         macro_addr = macro_base
            + 16'({8'h00, emul_instr[emul_op_msb:emul_op_lsb]} << macro_shift); // RQ19
      end
      is_multiword_move = (emul_instr[emul_op_msb:emul_op_lsb] == multiword_move_opcode);
   end
endmodule

/* File: hdl/dual_mode_fetch_sequencer.sv */
// Summary of operation
// RQ1 - Pin high selects emulation, low native
// RQ2 - Native: separate buses, fetch overlaps execute
// RQ3 - Thirty native instructions, mostly two cycles
// RQ4 - Emulation: one shared bus for everything
// RQ5 - Native drives all twenty instruction lines
// RQ6 - Load/store registers from instruction memory
// RQ7 - Fetch to holding reg, execute; idle buses
// RQ8 - Operand need raises request mid next cycle
// RQ9 - Grant and busy sampled on falling edges
// RQ10 - Acknowledge grant once previous master released
// RQ11 - Strobes low while address and data valid
// RQ12 - Cycle extends until transfer acknowledge
// RQ13 - Native interrupts open; register read/write commands
// RQ14 - Emulation: sixteen address lines, four discretes
// RQ15 - Top address bit becomes chip select
// RQ16 - Bits 16 to 18 are three discretes
// RQ17 - Discretes reset to 1, 0, 0
// RQ18 - Emulation starts fetching at address zero
// RQ19 - Opcode maps to macro; then fetch next
// RQ20 - Interrupts wait for macro completion
// RQ21 - Multiword move interruptible per word
// RQ22 - Builtin opcode maps to 256 user macros
// RQ23 - Output register command programs the discretes
// RQ24 - Release request and acknowledge after transfer
module dual_mode_fetch_sequencer
   import fetch_seq_pkg::*;
(
   input wire logic clk_sys, // System clock, 50 MHz
   input wire logic reset, // Sync reset, high
   input wire logic mode_select_pin, // High selects emulation
   output logic [fetch_seq_pkg::instr_addr_width-1:0] instr_addr_out, // Instruction address
   input wire logic [15:0] instr_data_in, // Instruction bus read
   output logic [15:0] instr_data_out, // Instruction bus write
   output logic instr_data_oe_n, // Instruction data drive, low
   output logic instr_write_out, // Instruction memory write strobe
   input wire logic bus_grant_in, // Operand bus grant
   input wire logic bus_busy_in, // Operand bus busy
   input wire logic transfer_ack_n, // Operand transfer ack, low
   input wire logic [15:0] op_data_in, // Operand data read
   output logic bus_request_out, // Operand bus request
   output logic grant_acknowledge_out, // Operand bus owned
   output logic addr_strobe_n, // Address strobe, low
   output logic data_strobe_n, // Data strobe, low
   output logic [15:0] op_addr_out, // Operand address
   output logic [15:0] op_data_out, // Operand write data
   output logic op_data_oe_n, // Operand data drive, low
   input wire logic interrupt_in, // Pending interrupt level
   output logic interrupt_taken, // Interrupt accepted pulse
   output logic [15:0] acc_out // Working register view
);
   typedef enum logic [5:0] {
      st_fetch = 6'h01,
      st_exec = 6'h02,
      st_operand = 6'h04,
      st_emul_fetch = 6'h08,
      st_emul_wait = 6'h10,
      st_imem = 6'h20
   } seq_state_type;

   seq_state_type state;
   logic emulation;
   logic [19:0] pc;
   logic [15:0] primary_instr_holding_reg;
   logic [15:0] executing_instr_reg;
   logic [15:0] acc;
   logic [3:0] discretes;
   logic in_macro;
   logic move_macro;
   logic [15:0] emul_pc;
   logic [15:0] mapped_addr;
   logic mapped_move;
   logic fetch_valid;

   operand_bus_if obus ();

   // Decode top six bits of a native word
   function automatic logic [5:0] opcode_of(input logic [15:0] w);
      opcode_of = w[opcode_msb:opcode_lsb];
   endfunction

   function automatic logic needs_operand(input logic [15:0] w);
      needs_operand = (opcode_of(w) == op_load_operand)
         || (opcode_of(w) == op_store_operand);
   endfunction

   ////////////////////////////////////////////////////////////////
   // Operating mode caught in st_fetch whenever fetch_valid and in_macro are low
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         emulation <= 1'b0;
      end else if (state == st_fetch && !fetch_valid && !in_macro) begin
         emulation <= mode_select_pin; // RQ1
      end
   end

   ////////////////////////////////////////////////////////////////
   // Instruction address: full 20 bits natively, 16 plus discretes
   always_comb begin
      if (emulation) begin
         instr_addr_out = {discretes, pc[15:0]}; // RQ14 RQ15 RQ16
      end else begin
         instr_addr_out = pc; // RQ5
      end
   end

   // Discretes: chip select top, then startup, power, dma
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         discretes <= discrete_reset; // RQ17
      end else if (state == st_exec
            && opcode_of(executing_instr_reg) == op_output_register_cmd
            && executing_instr_reg[3:0] == discrete_select) begin
         discretes <= acc[3:0]; // RQ23
      end
   end

   macro_address_map mapper (
      .emul_instr(obus.rdata),
      .macro_addr(mapped_addr),
      .is_multiword_move(mapped_move)
   );

   operand_bus_arbiter arbiter (
      .clk_sys(clk_sys),
      .reset(reset),
      .req(obus),
      .bus_grant_in(bus_grant_in),
      .bus_busy_in(bus_busy_in),
      .transfer_ack_n(transfer_ack_n),
      .op_data_in(op_data_in),
      .bus_request_out(bus_request_out),
      .grant_acknowledge_out(grant_acknowledge_out),
      .addr_strobe_n(addr_strobe_n),
      .data_strobe_n(data_strobe_n),
      .op_addr_out(op_addr_out),
      .op_data_out(op_data_out),
      .op_data_oe_n(op_data_oe_n)
   );

   ////////////////////////////////////////////////////////////////
   // Operand bus requests from the sequencer
   always_comb begin
      obus.start = 1'b0;
      obus.write = 1'b0;
      obus.addr = emul_pc;
      obus.wdata = acc;
      if (state == st_emul_fetch) begin
         obus.start = 1'b1; // RQ4 RQ18
      end else if (state == st_exec && needs_operand(executing_instr_reg)) begin
         obus.start = 1'b1; // RQ8
         obus.write = (opcode_of(executing_instr_reg) == op_store_operand);
         obus.addr = executing_instr_reg[15:0] & 16'h03FF;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Fetch, execute and macro sequencing
   // Each native word costs a fetch and an execute cycle; the next
   // fetch overlaps execute so most instructions take two cycles.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state <= st_fetch;
         pc <= native_reset_addr;
         emul_pc <= first_emul_addr; // RQ18
         primary_instr_holding_reg <= 16'h0000;
         executing_instr_reg <= 16'h0000;
         fetch_valid <= 1'b0;
         in_macro <= 1'b0;
         move_macro <= 1'b0;
         interrupt_taken <= 1'b0;
      end else begin
         interrupt_taken <= 1'b0;
         case (state)
            st_fetch: begin
               if (emulation && !in_macro) begin
                  state <= st_emul_fetch; // RQ19
               end else begin
                  primary_instr_holding_reg <= instr_data_in; // RQ7
                  pc <= 20'(pc + 20'h00001);
                  fetch_valid <= 1'b1;
                  if (fetch_valid) begin
                     executing_instr_reg <= primary_instr_holding_reg;
                     state <= st_exec;
                  end
               end
            end
            st_exec: begin
               // Overlap: next word lands while this executes
               primary_instr_holding_reg <= instr_data_in; // RQ2
               pc <= 20'(pc + 20'h00001);
               executing_instr_reg <= primary_instr_holding_reg; // RQ3
               if (needs_operand(executing_instr_reg)) begin
                  state <= st_operand;
               end else if (opcode_of(executing_instr_reg) == op_load_from_instr_mem
                     || opcode_of(executing_instr_reg) == op_store_to_instr_mem) begin
                  pc <= {10'h000, executing_instr_reg[9:0]}; // RQ6
                  state <= st_imem;
               end else if (in_macro && opcode_of(executing_instr_reg) == op_macro_return) begin
                  // Macro done: interrupts may now be seen
                  in_macro <= 1'b0;
                  move_macro <= 1'b0;
                  fetch_valid <= 1'b0;
                  interrupt_taken <= interrupt_in; // RQ20
                  state <= st_fetch;
               end else if (move_macro && opcode_of(executing_instr_reg) == op_word_done
                     && interrupt_in) begin
                  // Move yields after the current word
                  in_macro <= 1'b0; // RQ21
                  move_macro <= 1'b0;
                  fetch_valid <= 1'b0;
                  interrupt_taken <= 1'b1;
                  state <= st_fetch;
               end else if (!in_macro && !emulation && interrupt_in) begin
                  interrupt_taken <= 1'b1; // RQ13
                  fetch_valid <= 1'b0;
                  state <= st_fetch;
               end
            end
            st_operand: begin
               // Prefetched words wait; dropping them would skip code
               if (obus.done) begin
                  state <= st_exec;
               end
            end
            st_imem: begin
               fetch_valid <= 1'b0;
               state <= st_fetch;
            end
            st_emul_fetch: begin
               state <= st_emul_wait;
            end
            st_emul_wait: begin
               if (obus.done) begin
                  emul_pc <= 16'(emul_pc + 16'h0001);
                  pc <= {4'h0, mapped_addr}; // RQ19 RQ22
                  in_macro <= 1'b1;
                  move_macro <= mapped_move;
                  fetch_valid <= 1'b0;
                  state <= st_fetch;
               end
            end
            default: state <= st_fetch;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // Working register and register-access commands
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         acc <= 16'h0000;
      end else if (state == st_operand && obus.done && !obus.write) begin
         acc <= obus.rdata;
      end else if (state == st_imem
            && opcode_of(executing_instr_reg) == op_load_from_instr_mem) begin
         acc <= instr_data_in; // RQ6
      end else if (state == st_exec
            && opcode_of(executing_instr_reg) == op_internal_input_cmd) begin
         acc <= {12'h000, discretes}; // RQ13
      end
   end

   // Instruction memory write for the store command
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         instr_write_out <= 1'b0;
         instr_data_oe_n <= 1'b1;
         instr_data_out <= 16'h0000;
      end else begin
         instr_write_out <= (state == st_exec
            && opcode_of(executing_instr_reg) == op_store_to_instr_mem); // RQ6
         instr_data_oe_n <= !(state == st_exec
            && opcode_of(executing_instr_reg) == op_store_to_instr_mem);
         instr_data_out <= acc;
      end
   end

   assign acc_out = acc;
endmodule

/* File: bench/fetch_seq_chk.sv */
module fetch_seq_chk (
   input wire logic clk_sys, // System clock
   input wire logic reset, // Sync reset, high
   input wire logic bus_grant_in, // Grant in
   input wire logic bus_busy_in, // Busy in
   input wire logic transfer_ack_n, // Slave ready, low
   input wire logic bus_request_out, // Request out
   input wire logic grant_acknowledge_out, // Bus owned
   input wire logic addr_strobe_n, // Address strobe, low
   input wire logic data_strobe_n, // Data strobe, low
   input wire logic [15:0] op_addr_out, // Operand address
   input wire logic op_data_oe_n, // Data drive, low
   input wire logic interrupt_in, // Interrupt level
   input wire logic interrupt_taken // Interrupt accepted
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////////////
   // Both strobes mark one valid address and data phase
   property p_strobe_pair; addr_strobe_n == data_strobe_n; endproperty
   a_strobe_pair: assert property (p_strobe_pair) else $error("strobes split");
   property p_strobe_own; !addr_strobe_n |-> grant_acknowledge_out && bus_request_out; endproperty
   a_strobe_own: assert property (p_strobe_own) else $error("strobe without bus");
   property p_hold_wait; !addr_strobe_n && transfer_ack_n |=> !addr_strobe_n; endproperty
   a_hold_wait: assert property (p_hold_wait) else $error("cycle not extended");
   property p_end_cycle; !addr_strobe_n && !transfer_ack_n |=> addr_strobe_n; endproperty
   a_end_cycle: assert property (p_end_cycle) else $error("cycle not ended");
   // Address may not move under a slow slave
   property p_addr_hold; !addr_strobe_n |=> addr_strobe_n || $stable(op_addr_out); endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address moved");
   // Ownership only once the old master has gone
   property p_ack_cause; $rose(grant_acknowledge_out) |-> $past(bus_grant_in && !bus_busy_in);
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack too early");
   property p_ack_req; $rose(grant_acknowledge_out) |-> bus_request_out; endproperty
   a_ack_req: assert property (p_ack_req) else $error("ack without request");
   property p_release; $rose(addr_strobe_n) |=> !grant_acknowledge_out && !bus_request_out;
   endproperty
   a_release: assert property (p_release) else $error("bus not released");
   // Never drive data onto a bus we do not own
   property p_oe_own; !op_data_oe_n |-> grant_acknowledge_out; endproperty
   a_oe_own: assert property (p_oe_own) else $error("data driven unowned");
   property p_int_cause; interrupt_taken |-> $past(interrupt_in) ##1 !interrupt_taken; endproperty
   a_int_cause: assert property (p_int_cause) else $error("bad interrupt pulse");
   c_cycle: cover property (!addr_strobe_n && !transfer_ack_n);
endmodule
////////////////////////////////////////////////////////////////////////////
bind dual_mode_fetch_sequencer fetch_seq_chk fetch_seq_chk_inst (.clk_sys, .reset,
   .bus_grant_in, .bus_busy_in, .transfer_ack_n, .bus_request_out, .grant_acknowledge_out,
   .addr_strobe_n, .data_strobe_n, .op_addr_out, .op_data_oe_n, .interrupt_in,
   .interrupt_taken);

/* File: bench/operand_side_model.sv */
module operand_side_model (
   input wire logic clk_sys, // System clock
   input wire logic reset, // Sync reset, high
   input wire logic bus_request_out, // Request from device
   input wire logic grant_acknowledge_out, // Device owns bus
   input wire logic addr_strobe_n, // Address strobe, low
   input wire logic [15:0] op_addr_out, // Operand address
   input wire logic [15:0] op_data_out, // Write data
   input wire logic op_data_oe_n, // Device drives data, low
   input wire logic [3:0] wait_states, // Slave delay
   input wire logic [3:0] busy_time, // Old master hold time
   output logic bus_grant_in, // Grant
   output logic bus_busy_in, // Old master busy
   output logic transfer_ack_n, // Ready, low
   output logic [15:0] op_data_in // Read data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [0:255];
   logic [15:0] addr_log [$];
   logic [15:0] last_rdata;
   int rq_cnt;
   int wt_cnt;
   ////////////////////////////////////////////////////////////////////////
   // Grant at once, but the old master keeps the bus busy a while
   always_ff @(posedge clk_sys) begin
      if (reset || !bus_request_out) begin
         rq_cnt <= 0;
         bus_grant_in <= 1'b0;
         bus_busy_in <= 1'b0;
      end else begin
         rq_cnt <= rq_cnt + 1;
         bus_grant_in <= 1'b1;
         bus_busy_in <= !grant_acknowledge_out && rq_cnt < busy_time;
      end
   end
   // Slow slave: ack held off, then one cycle low
   always @(posedge clk_sys) begin
      if (reset || addr_strobe_n || !transfer_ack_n) begin
         wt_cnt <= 0;
         transfer_ack_n <= 1'b1;
      end else begin
         wt_cnt <= wt_cnt + 1;
         if (wt_cnt >= wait_states) begin
            transfer_ack_n <= 1'b0;
            addr_log.push_back(op_addr_out);
            if (!op_data_oe_n) mem[op_addr_out[7:0]] <= op_data_out;
            else last_rdata <= mem[op_addr_out[7:0]];
         end
      end
   end
   // Released bus shows the inverse of the last word, not a stale copy
   assign op_data_in = !op_data_oe_n ? op_data_out :
      (addr_strobe_n ? ~last_rdata : mem[op_addr_out[7:0]]);
endmodule

/* File: bench/dual_mode_fetch_sequencer_tb_top.sv */
module dual_mode_fetch_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import fetch_seq_pkg::*;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic mode_select_pin = 1'b0;
   logic interrupt_in = 1'b0;
   logic [3:0] wait_states = 4'h0;
   logic [3:0] busy_time = 4'h0;
   logic [19:0] instr_addr_out;
   logic [15:0] instr_data_in, instr_data_out, op_data_in, op_data_out, op_addr_out, acc_out;
   logic instr_data_oe_n, instr_write_out, bus_grant_in, bus_busy_in, transfer_ack_n;
   logic bus_request_out, grant_acknowledge_out, addr_strobe_n, data_strobe_n, op_data_oe_n;
   logic interrupt_taken;
   logic [15:0] imem [0:8191];
   logic [7:0] op_table [0:4] = '{8'h4F, 8'h93, 8'h00, 8'hFF, 8'h4F};
   int n_fail = 0;
   int n_compared = 0;
   ////////////////////////////////////////////////////////////////////////
   initial begin
      forever #10 clk_sys = ~clk_sys;
   end
   // Instruction bus level worked out from both drivers
   assign instr_data_in = instr_data_oe_n ? imem[instr_addr_out[12:0]] : instr_data_out;
   always_ff @(posedge clk_sys) begin
      if (instr_write_out) imem[instr_addr_out[12:0]] <= instr_data_out;
   end
   dual_mode_fetch_sequencer dual_mode_fetch_sequencer_inst (.clk_sys, .reset,
      .mode_select_pin, .instr_addr_out, .instr_data_in, .instr_data_out, .instr_data_oe_n,
      .instr_write_out, .bus_grant_in, .bus_busy_in, .transfer_ack_n, .op_data_in,
      .bus_request_out, .grant_acknowledge_out, .addr_strobe_n, .data_strobe_n, .op_addr_out,
      .op_data_out, .op_data_oe_n, .interrupt_in, .interrupt_taken, .acc_out);
   operand_side_model operand_side_model_inst (.clk_sys, .reset, .bus_request_out,
      .grant_acknowledge_out, .addr_strobe_n, .op_addr_out, .op_data_out, .op_data_oe_n,
      .wait_states, .busy_time, .bus_grant_in, .bus_busy_in, .transfer_ack_n, .op_data_in);
   ////////////////////////////////////////////////////////////////////////
   // Expected macro entry from the fetched emulated word
   function automatic logic [15:0] macro_expect(input logic [15:0] w);
      if (w[15:8] == builtin_function_opcode) return builtin_base + ({8'h00, w[7:0]} << builtin_shift);
      return macro_base + ({8'h00, w[15:8]} << macro_shift);
   endfunction
   task automatic check(input logic [19:0] exp, input logic [19:0] got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: expected %h got %h", $time, exp, got);
      end
   endtask
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Reset with fresh random slave timing; four cycles held
   task automatic do_reset(input logic m);
      @(posedge clk_sys);
      reset <= 1'b1;
      mode_select_pin <= m;
      wait_states <= 4'($urandom_range(0, 5));
      busy_time <= 4'($urandom_range(0, 3));
      interrupt_in <= 1'($urandom_range(0, 1));
      repeat (4) @(posedge clk_sys);
      reset <= 1'b0;
      operand_side_model_inst.addr_log.delete();
      #1;
   endtask
   // Bounded waits; running out counts as a mismatch
   task automatic wait_addr(input logic [15:0] a);
      int i;
      for (i = 0; i < 400 && instr_addr_out[15:0] !== a; i++) @(posedge clk_sys) #1;
      if (i == 400) begin
         n_fail++;
         report_and_stop();
      end
   endtask
   task automatic wait_xfers(input int n);
      int i;
      for (i = 0; i < 600 && operand_side_model_inst.addr_log.size() < n; i++)
         @(posedge clk_sys) #1;
      if (i == 600) begin
         n_fail++;
         report_and_stop();
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [15:0] w;
      void'($urandom(5904));
      for (int i = 0; i < 8192; i++) imem[i] = {op_macro_return, 10'h000};
      for (int i = 0; i < 256; i++) operand_side_model_inst.mem[i] = 16'($urandom());
      for (int i = 0; i < 16; i++) imem[i] = {op_load_operand, 10'(i + 16)};
      // Native: full-width address from zero, operand loads arbitrate
      do_reset(1'b0);
      check(native_reset_addr, instr_addr_out);
      wait_xfers(4);
      check(20'h13, 20'(operand_side_model_inst.addr_log[3]));
      repeat (2) @(posedge clk_sys) #1;
      check(operand_side_model_inst.mem[8'h13], acc_out);
      do_reset(1'b0);
      wait_xfers(2);
      check(20'h10, 20'(operand_side_model_inst.addr_log[0]));
      for (int i = 0; i < 16; i++) imem[i] = {op_macro_return, 10'h000};
      // Emulation: corner opcodes, then random ones
      for (int k = 0; k < 9; k++) begin
         w = {(k < 5) ? op_table[k] : 8'($urandom()), 8'($urandom())};
         operand_side_model_inst.mem[0] = w;
         do_reset(1'b1);
         wait_addr(macro_expect(w));
         check({20'(macro_expect(w))} | {discrete_reset, 16'h0000}, instr_addr_out);
         check(discrete_reset, instr_addr_out[19:16]);
         wait_xfers(2);
         check(20'(first_emul_addr), 20'(operand_side_model_inst.addr_log[0]));
         check(20'h00001, 20'(operand_side_model_inst.addr_log[1]));
      end
      report_and_stop();
   end
endmodule
